/* File: rtl/cps_defs.svh */
`ifndef CPS_DEFS_SVH
`define CPS_DEFS_SVH

`define CPS_CLK_MHZ      100
`define CPS_PERIOD_US    400
`define CPS_CONV_US      40
`define CPS_PWRUP_US     4
`define CPS_PIN_GAP_US   40
`define CPS_MAX_RATE_HZ  2500
`define CPS_ADDR_FIXED   4'h9
`define CPS_PTR_CFG      8'h01
`define CPS_PTR_CFG2     8'h04
`define CPS_SHDN_BIT     0
`define CPS_PINMODE_BIT  7
`define CPS_CFG_RESET    8'h00

`endif

/* File: rtl/cps_pkg.sv */
package cps_pkg;

   typedef enum {
      ST_FULL_PD,
      ST_IDLE,
      ST_CONVERT,
      ST_ABORT,
      ST_PIN_WAIT,
      ST_PIN_PD,
      ST_POWERUP
   } seq_state_e;

   // Each field is a toggle: an edge means one event
   typedef struct packed {
      logic read;
      logic stop;
      logic wake;
      logic cfg;
      logic cfg2;
   } link_evt_s;

endpackage

/* File: rtl/cps_sync2.sv */
`timescale 1ns/1ps
`default_nettype none
module cps_sync2 #(
   parameter int W = 1
) (
   input  wire logic         i_clk,
   input  wire logic         i_rst_n,
   input  wire logic [W-1:0] i_d,
   output logic      [W-1:0] o_q
);
   logic [W-1:0] meta_reg;
   logic [W-1:0] q_reg;

   // First stage feeds only the second stage
   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         meta_reg <= '0;
         q_reg    <= '0;
      end
      else
      begin
         meta_reg <= i_d;
         q_reg    <= meta_reg;
      end
   end

   assign o_q = q_reg;
endmodule
`default_nettype wire

/* File: rtl/cps_link_front.sv */
`timescale 1ns/1ps
`default_nettype none
`include "cps_defs.svh"
module cps_link_front
   import cps_pkg::*;
(
   input  wire logic       i_link_clk,
   input  wire logic       i_resetn,
   input  wire logic [2:0] i_addr_sel,
   input  wire logic       i_addr_stb,
   input  wire logic [6:0] i_addr,
   input  wire logic       i_rnw,
   input  wire logic       i_wr_stb,
   input  wire logic [7:0] i_ptr,
   input  wire logic [7:0] i_wr_data,
   input  wire logic       i_stop,
   output logic            o_ack,
   output link_evt_s       o_evt,
   output logic [7:0]      o_cfg,
   output logic [7:0]      o_cfg2
);
   logic       rst_n;
   logic [2:0] sel_pins;
   logic       sel_reg;
   logic       rnw_reg;
   logic       ack_reg;
   link_evt_s  evt_reg;
   logic [7:0] cfg_reg;
   logic [7:0] cfg2_reg;

   cps_sync2 #(.W(1)) u_rst (
      .i_clk   (i_link_clk),
      .i_rst_n (i_resetn),
      .i_d     (1'b1),
      .o_q     (rst_n)
   );

   cps_sync2 #(.W(3)) u_sel (
      .i_clk   (i_link_clk),
      .i_rst_n (rst_n),
      .i_d     (i_addr_sel),
      .o_q     (sel_pins)
   );

   wire match   = (i_addr == {`CPS_ADDR_FIXED, sel_pins});
   wire hit     = i_addr_stb & match;
   wire wr_ok   = i_wr_stb & sel_reg & ~rnw_reg;
   wire cfg_wr  = wr_ok & (i_ptr == `CPS_PTR_CFG);
   wire cfg2_wr = wr_ok & (i_ptr == `CPS_PTR_CFG2);
   wire end_tr  = i_stop & sel_reg;

   always_ff @(posedge i_link_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         sel_reg  <= 1'b0;
         rnw_reg  <= 1'b0;
         ack_reg  <= 1'b0;
         evt_reg  <= '0;
         cfg_reg  <= `CPS_CFG_RESET;
         cfg2_reg <= `CPS_CFG_RESET;
      end
      else
      begin
         sel_reg       <= i_addr_stb ? match : (sel_reg & ~i_stop);
         rnw_reg       <= i_addr_stb ? i_rnw : rnw_reg;
         ack_reg       <= hit;
         evt_reg.read  <= evt_reg.read ^ (hit & i_rnw);
         evt_reg.stop  <= evt_reg.stop ^ end_tr;
         evt_reg.wake  <= evt_reg.wake ^ (end_tr & ~rnw_reg);
         evt_reg.cfg   <= evt_reg.cfg ^ cfg_wr;
         evt_reg.cfg2  <= evt_reg.cfg2 ^ cfg2_wr;
         // Data is held until the next write, long after the core samples it
         cfg_reg       <= cfg_wr ? i_wr_data : cfg_reg;
         cfg2_reg      <= cfg2_wr ? i_wr_data : cfg2_reg;
      end
   end

   assign o_ack  = ack_reg;
   assign o_evt  = evt_reg;
   assign o_cfg  = cfg_reg;
   assign o_cfg2 = cfg2_reg;
endmodule
`default_nettype wire

/* File: rtl/conversion_power_sequencer.sv */
`timescale 1ns/1ps
`default_nettype none
`include "cps_defs.svh"
module conversion_power_sequencer
   import cps_pkg::*;
#(
   parameter int P_PERIOD_CYC = `CPS_PERIOD_US * `CPS_CLK_MHZ,
   parameter int P_CONV_CYC   = `CPS_CONV_US * `CPS_CLK_MHZ,
   parameter int P_PWRUP_CYC  = `CPS_PWRUP_US * `CPS_CLK_MHZ,
   parameter int P_CNT_W      = 16
) (
   input  wire logic       I_CLK,
   input  wire logic       I_RESETN,
   input  wire logic       I_CONVERSION_START_PIN,
   input  wire logic       I_LINK_CLK,
   input  wire logic [2:0] I_ADDR_SEL,
   input  wire logic       I_LINK_ADDR_STB,
   input  wire logic [6:0] I_LINK_ADDR,
   input  wire logic       I_LINK_RNW,
   input  wire logic       I_LINK_WR_STB,
   input  wire logic [7:0] I_LINK_PTR,
   input  wire logic [7:0] I_LINK_WR_DATA,
   input  wire logic       I_LINK_STOP,
   output logic            O_LINK_ACK,
   output logic            O_HOLD,
   output logic            O_POWERED,
   output logic            O_FULL_PD,
   output logic            O_RESULT_UPDATE,
   output logic            O_OTI_CLEAR,
   output logic            O_SHUTDOWN,
   output logic            O_PIN_MODE
);
   localparam logic [P_CNT_W-1:0] PERIOD_LAST = P_CNT_W'(P_PERIOD_CYC - 1);
   localparam logic [P_CNT_W-1:0] CONV_LAST   = P_CNT_W'(P_CONV_CYC - 1);
   localparam logic [P_CNT_W-1:0] PWRUP_LAST  = P_CNT_W'(P_PWRUP_CYC - 1);
   localparam logic [P_CNT_W-1:0] CNT_ONE     = P_CNT_W'(1);

   generate
      if (P_CONV_CYC < 1 || P_PWRUP_CYC < 1 || P_CONV_CYC >= P_PERIOD_CYC ||
          P_PERIOD_CYC >= (1 << P_CNT_W) || P_CNT_W > 30)
      begin : g_bad_params
         $error("conversion_power_sequencer: counts do not fit the counters");
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // Reset release, link front end and crossings

   logic       rst_n;
   link_evt_s  evt_link;
   link_evt_s  evt_sync;
   link_evt_s  evt_seen_reg;
   logic [7:0] cfg_link;
   logic [7:0] cfg2_link;
   logic       pin_level;
   logic       pin_d_reg;

   cps_sync2 #(.W(1)) u_rst (
      .i_clk   (I_CLK),
      .i_rst_n (I_RESETN),
      .i_d     (1'b1),
      .o_q     (rst_n)
   );

   // Serial side runs on its own clock, whatever the power state
   cps_link_front u_front (
      .i_link_clk (I_LINK_CLK),
      .i_resetn   (I_RESETN),
      .i_addr_sel (I_ADDR_SEL),
      .i_addr_stb (I_LINK_ADDR_STB),
      .i_addr     (I_LINK_ADDR),
      .i_rnw      (I_LINK_RNW),
      .i_wr_stb   (I_LINK_WR_STB),
      .i_ptr      (I_LINK_PTR),
      .i_wr_data  (I_LINK_WR_DATA),
      .i_stop     (I_LINK_STOP),
      .o_ack      (O_LINK_ACK),
      .o_evt      (evt_link),
      .o_cfg      (cfg_link),
      .o_cfg2     (cfg2_link)
   );

   cps_sync2 #(.W($bits(link_evt_s))) u_evt (
      .i_clk   (I_CLK),
      .i_rst_n (rst_n),
      .i_d     (evt_link),
      .o_q     (evt_sync)
   );

   cps_sync2 #(.W(1)) u_pin (
      .i_clk   (I_CLK),
      .i_rst_n (rst_n),
      .i_d     (I_CONVERSION_START_PIN),
      .o_q     (pin_level)
   );

   wire [$bits(link_evt_s)-1:0] evt_pulse = evt_sync ^ evt_seen_reg;
   link_evt_s ev;
   assign ev = link_evt_s'(evt_pulse);

   wire read_ev  = ev.read;
   wire stop_ev  = ev.stop;
   wire wake_ev  = ev.wake;
   wire cfg_ev   = ev.cfg;
   wire cfg2_ev  = ev.cfg2;
   wire pin_rise = pin_level & ~pin_d_reg;
   wire pin_fall = ~pin_level & pin_d_reg;

   ////////////////////////////////////////////////////////////////////////////
   // Control bits

   logic shutdown_reg;
   logic pin_mode_reg;

   wire shutdown_next = cfg_ev ? cfg_link[`CPS_SHDN_BIT] : shutdown_reg;
   wire pin_mode_next = cfg2_ev ? cfg2_link[`CPS_PINMODE_BIT] : pin_mode_reg;
   wire oti_clr_next  = cfg_ev & cfg_link[`CPS_SHDN_BIT];

   ////////////////////////////////////////////////////////////////////////////
   // Sequencer

   seq_state_e         state_reg;
   seq_state_e         state_next;
   logic [P_CNT_W-1:0] conv_cnt_reg;
   logic [P_CNT_W-1:0] period_cnt_reg;
   logic [P_CNT_W-1:0] pu_cnt_reg;
   logic               rd_pend_reg;

   wire conv_end   = (state_reg == ST_CONVERT) & (conv_cnt_reg == CONV_LAST);
   wire period_hit = (period_cnt_reg == PERIOD_LAST);
   wire pu_done    = (pu_cnt_reg == PWRUP_LAST);
   // Where a finished conversion goes, also used after a pin-mode change
   seq_state_e         after_conv;
   assign after_conv = shutdown_reg ? ST_FULL_PD :
                       !pin_mode_reg ? ST_IDLE :
                       pin_level ? ST_PIN_WAIT : ST_PIN_PD;

   always_comb
   begin
      state_next = state_reg;
      case (state_reg)
         ST_FULL_PD:
            if (!shutdown_reg)
               state_next = ST_IDLE;
            else if (wake_ev)
               state_next = ST_CONVERT;
         ST_IDLE:
            if (shutdown_reg || pin_mode_reg)
               state_next = after_conv;
            else if ((stop_ev && rd_pend_reg) || period_hit)
               state_next = ST_CONVERT;
         ST_CONVERT:
            if (read_ev)
               state_next = ST_ABORT;
            else if (conv_end)
               state_next = after_conv;
         ST_ABORT:
            if (stop_ev)
               state_next = ST_CONVERT;
         ST_PIN_WAIT:
            if (shutdown_reg || !pin_mode_reg)
               state_next = after_conv;
            else if (pin_fall)
               state_next = ST_CONVERT;
         ST_PIN_PD:
            if (shutdown_reg || !pin_mode_reg)
               state_next = after_conv;
            else if (pin_rise)
               state_next = ST_POWERUP;
         ST_POWERUP:
            if (shutdown_reg || !pin_mode_reg)
               state_next = after_conv;
            else if (pu_done && !pin_level)
               state_next = ST_CONVERT;
         default:
            state_next = ST_FULL_PD;
      endcase
   end

   wire conv_start = (state_next == ST_CONVERT) & (state_reg != ST_CONVERT);
   wire pu_start   = (state_next == ST_POWERUP) & (state_reg != ST_POWERUP);

   // Counters saturate so a long wait cannot wrap into a false hit
   wire [P_CNT_W-1:0] conv_cnt_next   = conv_start ? '0 :
        (conv_cnt_reg == CONV_LAST) ? conv_cnt_reg : conv_cnt_reg + CNT_ONE;
   wire [P_CNT_W-1:0] period_cnt_next = conv_start ? '0 :
        period_hit ? period_cnt_reg : period_cnt_reg + CNT_ONE;
   wire [P_CNT_W-1:0] pu_cnt_next     = pu_start ? '0 :
        pu_done ? pu_cnt_reg : pu_cnt_reg + CNT_ONE;

   // Set wins over clear: a read in the very start cycle stays pending
   wire rd_pend_next = (read_ev & (state_reg == ST_IDLE)) | (rd_pend_reg & ~conv_start);
   // An aborted conversion leaves the previous result in place
   wire result_next  = conv_end & ~read_ev;
   wire hold_next    = (state_next == ST_CONVERT);
   wire powered_next = (state_next == ST_CONVERT) | (state_next == ST_ABORT) |
                       (state_next == ST_PIN_WAIT) | (state_next == ST_POWERUP);

   always_ff @(posedge I_CLK or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_reg      <= ST_IDLE;
         conv_cnt_reg   <= '0;
         period_cnt_reg <= '0;
         pu_cnt_reg     <= '0;
         rd_pend_reg    <= 1'b0;
      end
      else
      begin
         state_reg      <= state_next;
         conv_cnt_reg   <= conv_cnt_next;
         period_cnt_reg <= period_cnt_next;
         pu_cnt_reg     <= pu_cnt_next;
         rd_pend_reg    <= rd_pend_next;
      end
   end

   always_ff @(posedge I_CLK or negedge rst_n)
   begin
      if (!rst_n)
      begin
         evt_seen_reg    <= '0;
         pin_d_reg       <= 1'b0;
         shutdown_reg    <= 1'b0;
         pin_mode_reg    <= 1'b0;
         O_HOLD          <= 1'b0;
         O_POWERED       <= 1'b0;
         O_FULL_PD       <= 1'b0;
         O_RESULT_UPDATE <= 1'b0;
         O_OTI_CLEAR     <= 1'b0;
         O_SHUTDOWN      <= 1'b0;
         O_PIN_MODE      <= 1'b0;
      end
      else
      begin
         evt_seen_reg    <= evt_sync;
         pin_d_reg       <= pin_level;
         shutdown_reg    <= shutdown_next;
         pin_mode_reg    <= pin_mode_next;
         O_HOLD          <= hold_next;
         O_POWERED       <= powered_next;
         O_FULL_PD       <= (state_next == ST_FULL_PD);
         O_RESULT_UPDATE <= result_next;
         O_OTI_CLEAR     <= oti_clr_next;
         O_SHUTDOWN      <= shutdown_next;
         O_PIN_MODE      <= pin_mode_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Checks

   default clocking cb_core @(posedge I_CLK);
   endclocking
   default disable iff (!rst_n);

   property p_shutdown_enter;
      shutdown_reg && (state_reg == ST_IDLE || state_reg == ST_PIN_PD)
      |=> state_reg == ST_FULL_PD ##1 O_FULL_PD;
   endproperty
   a_shutdown_enter: assert property (p_shutdown_enter)
      else $error("shutdown bit did not force full power-down");
   property p_wake_oneshot;
      state_reg == ST_FULL_PD && shutdown_reg && wake_ev && !cfg_ev && !read_ev
      |=> state_reg == ST_CONVERT && conv_cnt_reg == '0;
   endproperty
   a_wake_oneshot: assert property (p_wake_oneshot)
      else $error("bus write did not wake a conversion");
   property p_oneshot_return;
      conv_end && shutdown_reg && !read_ev |=> state_reg == ST_FULL_PD;
   endproperty
   a_oneshot_return: assert property (p_oneshot_return)
      else $error("one-shot conversion did not return to power-down");
   property p_read_abort;
      state_reg == ST_CONVERT && read_ev |=> state_reg == ST_ABORT ##1 !O_HOLD;
   endproperty
   a_read_abort: assert property (p_read_abort)
      else $error("read during conversion did not abort it");
   property p_abort_restart;
      state_reg == ST_ABORT && stop_ev |=> conv_cnt_reg == '0 ##1 O_HOLD;
   endproperty
   a_abort_restart: assert property (p_abort_restart)
      else $error("aborted conversion not restarted at stop");
   property p_abort_keeps_result;
      state_reg == ST_CONVERT && read_ev |=> !O_RESULT_UPDATE;
   endproperty
   a_abort_keeps_result: assert property (p_abort_keeps_result)
      else $error("aborted conversion updated the result");
   property p_pin_only;
      pin_mode_reg && state_reg == ST_IDLE |=> state_reg != ST_CONVERT;
   endproperty
   a_pin_only: assert property (p_pin_only)
      else $error("periodic conversion started in pin mode");
   property p_pin_high_stays_up;
      conv_end && !read_ev && pin_mode_reg && !shutdown_reg && pin_level
      |=> state_reg == ST_PIN_WAIT ##1 O_POWERED;
   endproperty
   a_pin_high_stays_up: assert property (p_pin_high_stays_up)
      else $error("pin-high method powered down");
   property p_pin_low_powers_down;
      conv_end && !read_ev && pin_mode_reg && !shutdown_reg && !pin_level
      |=> state_reg == ST_PIN_PD ##1 !O_POWERED;
   endproperty
   a_pin_low_powers_down: assert property (p_pin_low_powers_down)
      else $error("pin-low method stayed powered");
   property p_powerup_holdoff;
      state_reg == ST_POWERUP && !pu_done |=> state_reg != ST_CONVERT;
   endproperty
   a_powerup_holdoff: assert property (p_powerup_holdoff)
      else $error("conversion started before power-up time");
   property p_powerup_start;
      state_reg == ST_POWERUP && pu_done && !pin_level && pin_mode_reg && !shutdown_reg
      |=> state_reg == ST_CONVERT;
   endproperty
   a_powerup_start: assert property (p_powerup_start)
      else $error("conversion missing after power-up and pin low");
   property p_period;
      state_reg == ST_IDLE && period_hit && !shutdown_reg && !pin_mode_reg
      |=> state_reg == ST_CONVERT;
   endproperty
   a_period: assert property (p_period)
      else $error("periodic conversion missed");
   property p_oti_clear;
      cfg_ev && cfg_link[`CPS_SHDN_BIT] |=> O_OTI_CLEAR && O_SHUTDOWN;
   endproperty
   a_oti_clear: assert property (p_oti_clear)
      else $error("shutdown write did not clear indicator");

   c_oneshot: cover property (state_reg == ST_FULL_PD ##1 state_reg == ST_CONVERT);
   c_abort: cover property (state_reg == ST_ABORT ##1 state_reg == ST_CONVERT);
   c_powerup: cover property (state_reg == ST_POWERUP ##1 state_reg == ST_CONVERT);
   c_pin_wait: cover property (state_reg == ST_PIN_WAIT ##1 state_reg == ST_CONVERT);
endmodule
`default_nettype wire

/* File: tb/link_host.sv */
`timescale 1ns/1ps
`default_nettype none
module link_host (
   input  wire logic       i_lclk,
   input  wire logic       i_ack,
   output logic            o_astb,
   output logic [6:0]      o_addr,
   output logic            o_rnw,
   output logic            o_wstb,
   output logic [7:0]      o_ptr,
   output logic [7:0]      o_wdat,
   output logic            o_stop
);
   initial
   begin
      {o_astb, o_wstb, o_stop} = 3'h0;
      {o_addr, o_rnw, o_ptr, o_wdat} = 24'h00_0000;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Spacing covers the core's toggle crossing
   task automatic gap();
      repeat (5) @(posedge i_lclk);
   endtask

   task automatic addr(input logic [6:0] a, input logic rd, output logic ack);
      @(posedge i_lclk);
      o_astb <= 1'b1;
      o_addr <= a;
      o_rnw  <= rd;
      @(posedge i_lclk);
      o_astb <= 1'b0;
      // Released lines carry no stale value
      o_addr <= ~a;
      o_rnw  <= ~rd;
      @(posedge i_lclk);
      ack = i_ack;
      @(posedge i_lclk);
      ack = ack | i_ack;
      gap();
   endtask

   task automatic wbyte(input logic [7:0] p, input logic [7:0] d);
      @(posedge i_lclk);
      o_wstb <= 1'b1;
      o_ptr  <= p;
      o_wdat <= d;
      @(posedge i_lclk);
      o_wstb <= 1'b0;
      o_ptr  <= ~p;
      o_wdat <= ~d;
      gap();
   endtask

   task automatic stop();
      @(posedge i_lclk);
      o_stop <= 1'b1;
      @(posedge i_lclk);
      o_stop <= 1'b0;
      gap();
   endtask
endmodule
`default_nettype wire

/* File: tb/conversion_power_sequencer_tb.sv */
`timescale 1ns/1ps
`default_nettype none
`include "cps_defs.svh"
module conversion_power_sequencer_tb;
   localparam int PER = 200;
   localparam int CNV = 20;
   localparam int PWR = 10;
   logic       clk = 1'b0;
   logic       lclk = 1'b0;
   logic       rst_n = 1'b0;
   logic       pin = 1'b0;
   logic [2:0] sel = 3'h0;
   logic       astb, rnw, wstb, stp, ack, hold, pwr, fpd, upd, over_temp_indicator, shdn, pmd;
   logic [6:0] addr;
   logic [7:0] ptr, wdat;
   logic       hold_d = 1'b0;
   int         bad_count = 0;
   int         n_checks = 0;
   int         ups = 0;
   int         otis = 0;
   int         rises = 0;
   int         hlen = 0;
   int         hlast = 0;
   wire [3:0]  obs = {pmd, fpd, pwr, hold};

   always #5 clk = ~clk;
   always #7.5 lclk = ~lclk;

   // Non-blocking so a same-edge read is never a race
   always @(posedge clk)
   begin
      if (upd === 1'b1) ups <= ups + 1;
      if (over_temp_indicator === 1'b1) otis <= otis + 1;
      if (hold === 1'b1 && hold_d !== 1'b1) rises <= rises + 1;
      // Length of the last hold pulse, so a late look still sees it whole
      if (hold === 1'b1) hlen <= hlen + 1;
      else hlen <= 0;
      if (hold !== 1'b1 && hold_d === 1'b1) hlast <= hlen;
      hold_d <= hold;
   end

   conversion_power_sequencer #(
      .P_PERIOD_CYC (PER),
      .P_CONV_CYC   (CNV),
      .P_PWRUP_CYC  (PWR)
   ) conversion_power_sequencer_inst (
      .I_CLK(clk), .I_RESETN(rst_n), .I_CONVERSION_START_PIN(pin), .I_LINK_CLK(lclk),
      .I_ADDR_SEL(sel), .I_LINK_ADDR_STB(astb), .I_LINK_ADDR(addr), .I_LINK_RNW(rnw),
      .I_LINK_WR_STB(wstb), .I_LINK_PTR(ptr), .I_LINK_WR_DATA(wdat), .I_LINK_STOP(stp),
      .O_LINK_ACK(ack), .O_HOLD(hold), .O_POWERED(pwr), .O_FULL_PD(fpd),
      .O_RESULT_UPDATE(upd), .O_OTI_CLEAR(over_temp_indicator), .O_SHUTDOWN(shdn), .O_PIN_MODE(pmd)
   );

   link_host link_host_inst (
      .i_lclk(lclk), .i_ack(ack), .o_astb(astb), .o_addr(addr), .o_rnw(rnw),
      .o_wstb(wstb), .o_ptr(ptr), .o_wdat(wdat), .o_stop(stp)
   );

   ////////////////////////////////////////////////////////////////////////////
   task automatic end_sim();
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   task automatic chk_bit(input logic got, input logic exp, input string what);
      n_checks++;
      if (got !== exp)
      begin
         bad_count++;
         $display("unexpected at %0t: %s is %b", $time, what, got);
      end
   endtask

   task automatic chk_num(input int got, input int lo, input int hi, input string what);
      n_checks++;
      if (got < lo || got > hi)
      begin
         bad_count++;
         $display("unexpected at %0t: %s is %0d", $time, what, got);
      end
   endtask

   task automatic wait_sig(input int w, input logic v, input int maxc, output int n);
      n = 0;
      do
      begin
         @(posedge clk);
         n++;
         if (n > maxc)
         begin
            bad_count++;
            $display("unexpected at %0t: wait on output %0d timed out", $time, w);
            end_sim();
         end
      end while (obs[w] !== v);
   endtask

   task automatic wr(input logic [7:0] p, input logic [7:0] d);
      logic a;
      link_host_inst.addr({`CPS_ADDR_FIXED, sel}, 1'b0, a);
      chk_bit(a, 1'b1, "write ack");
      link_host_inst.wbyte(p, d);
      link_host_inst.stop();
   endtask

   // Pin moves only while the link is quiet
   task automatic pulse(input int hi);
      @(posedge clk);
      pin <= 1'b1;
      repeat (hi) @(posedge clk);
      pin <= 1'b0;
   endtask

   ////////////////////////////////////////////////////////////////////////////
   task automatic t_auto();
      int n1, n2, u0;
      wait_sig(0, 1'b1, 300, n1);
      chk_num(n1, PER, PER + 10, "first start");
      u0 = ups;
      wait_sig(0, 1'b0, 30, n2);
      chk_num(n2, CNV, CNV, "hold length");
      repeat (5) @(posedge clk);
      chk_bit(pwr, 1'b0, "powered between");
      chk_num(ups - u0, 1, 1, "result updates");
      wait_sig(0, 1'b1, 300, n1);
      chk_num(n1 + n2 + 5, PER, PER, "period");
      $display("test auto done");
   endtask

   task automatic t_addr();
      logic a;
      for (int s = 0; s < 8; s++)
      begin
         @(posedge lclk);
         sel <= s[2:0];
         repeat (4) @(posedge lclk);
         link_host_inst.addr({`CPS_ADDR_FIXED, s[2:0]}, 1'b0, a);
         chk_bit(a, 1'b1, "own address ack");
         link_host_inst.stop();
         link_host_inst.addr(s[0] ? {4'h6, s[2:0]} : {`CPS_ADDR_FIXED, s[2:0] + 3'd1}, 1'b0, a);
         chk_bit(a, 1'b0, "foreign address ack");
         link_host_inst.stop();
      end
      $display("test address done");
   endtask

   task automatic t_shdn();
      int n, o0, r0;
      logic a;
      o0 = otis;
      wr(`CPS_PTR_CFG, 8'h01);
      wait_sig(2, 1'b1, 100, n);
      chk_bit(shdn, 1'b1, "shutdown");
      chk_num(otis - o0, 1, 1, "indicator clears");
      repeat (60) @(posedge clk);
      link_host_inst.addr({`CPS_ADDR_FIXED, sel}, 1'b1, a);
      chk_bit(a, 1'b1, "read ack in power-down");
      link_host_inst.stop();
      r0 = rises;
      repeat (2 * PER) @(posedge clk);
      chk_num(rises - r0, 0, 0, "conversions while down");
      chk_bit(fpd, 1'b1, "full power-down");
      r0 = rises;
      o0 = ups;
      wr(`CPS_PTR_CFG, 8'h01);
      repeat (2 * PER) @(posedge clk);
      chk_num(rises - r0, 1, 1, "wake conversions");
      chk_num(ups - o0, 1, 1, "wake results");
      chk_bit(fpd, 1'b1, "back in power-down");
      $display("test shutdown done");
   endtask

   task automatic t_abort();
      int n, u0, r0;
      logic a;
      wr(`CPS_PTR_CFG, 8'h00);
      wait_sig(0, 1'b0, 500, n);
      wait_sig(0, 1'b1, 500, n);
      chk_bit(shdn, 1'b0, "shutdown cleared");
      u0 = ups;
      link_host_inst.addr({`CPS_ADDR_FIXED, sel}, 1'b1, a);
      chk_bit(hold, 1'b0, "hold after read");
      chk_num(ups - u0, 0, 0, "aborted results");
      link_host_inst.stop();
      wait_sig(0, 1'b1, 30, n);
      wait_sig(0, 1'b0, 30, n);
      repeat (2) @(posedge clk);
      chk_num(hlast, CNV, CNV, "restart length");
      chk_num(ups - u0, 1, 1, "restart results");
      r0 = rises;
      link_host_inst.addr({`CPS_ADDR_FIXED, sel}, 1'b1, a);
      chk_num(rises - r0, 0, 0, "start before stop");
      link_host_inst.stop();
      chk_num(rises - r0, 1, 1, "read then stop start");
      $display("test abort done");
   endtask

   task automatic t_pin();
      int n, r0;
      wr(`CPS_PTR_CFG2, 8'h80);
      wait_sig(3, 1'b1, 100, n);
      wait_sig(1, 1'b0, 60, n);
      r0 = rises;
      repeat (2 * PER) @(posedge clk);
      chk_num(rises - r0, 0, 0, "auto starts in pin mode");
      pulse(3);
      wait_sig(0, 1'b1, 30, n);
      chk_num(n + 3, PWR + 1, PWR + 6, "short pulse start");
      wait_sig(0, 1'b0, 30, n);
      repeat (3) @(posedge clk);
      chk_bit(pwr, 1'b0, "powered after low end");
      r0 = rises;
      repeat (CNV * 2) @(posedge clk);
      pulse(3 * PWR);
      chk_num(rises - r0, 0, 0, "starts while pin high");
      chk_bit(pwr, 1'b1, "powered while pin high");
      wait_sig(0, 1'b1, 8, n);
      repeat (5) @(posedge clk);
      pin <= 1'b1;
      wait_sig(0, 1'b0, 30, n);
      r0 = rises;
      repeat (100) @(posedge clk);
      chk_bit(pwr, 1'b1, "powered with pin high");
      chk_num(rises - r0, 0, 0, "starts before fall");
      pin <= 1'b0;
      wait_sig(0, 1'b1, 8, n);
      $display("test pin done");
   endtask

   initial
   begin
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      t_auto();
      t_addr();
      t_shdn();
      t_abort();
      t_pin();
      end_sim();
   end
endmodule
`default_nettype wire
